//--- common/guard_timer_pkg.sv
//==============================================================
// Purpose : Constants and types for the watchdog / interval timer
// Assumes : 25 MHz bus clock, 32 kHz low-speed tick from a pin
// Notes   : Register indices are word indices, byte address = 4 x index
package guard_timer_pkg;

    //==========================================================
    // Register map
    localparam logic [7:0]  CTRL_IDX      = 8'hc9;
    localparam logic [7:0]  IRQ_IDX       = 8'hca;
    localparam logic [11:0] CTRL_ADDR     = {2'h0, CTRL_IDX, 2'h0};
    localparam logic [11:0] IRQ_ADDR      = {2'h0, IRQ_IDX, 2'h0};
    localparam int          ADDR_W        = 12;

    //==========================================================
    // Control register fields
    localparam int          CLR_LSB       = 4;
    localparam int          MODE_LSB      = 2;
    localparam int          INT_LSB       = 0;
    localparam logic [3:0]  CLR_RESET     = 4'h0;
    localparam logic [1:0]  INT_RESET     = 2'h0;
    localparam logic [3:0]  CLEAR_KEY_ONE = 4'ha;
    localparam logic [3:0]  CLEAR_KEY_TWO = 4'h5;

    // Interrupt register fields
    localparam int          FLAG_BIT      = 0;
    localparam int          EN_BIT        = 1;
    localparam int          RSTREQ_BIT    = 2;

    //==========================================================
    // Counter and intervals, in low-speed clock periods
    localparam int          CNT_W         = 15;
    localparam logic [14:0] TERM_SEL0     = 15'h7ff1;
    localparam logic [14:0] TERM_SEL1     = 15'h2000;
    localparam logic [14:0] TERM_SEL2     = 15'h0200;
    localparam logic [14:0] TERM_SEL3     = 15'h0040;
    localparam logic [14:0] CNT_RESET     = 15'h0000;

    //==========================================================
    // Mode codes, usual path idle -> watchdog / timer
    typedef enum logic [1:0] {
        MODE_IDLE = 2'b00,
        MODE_WD   = 2'b10,
        MODE_TM   = 2'b11
    } mode_t;

    // Bus request latched at the address phase
    typedef struct packed {
        logic ctrl_wr;
        logic irq_wr;
        logic ctrl_rd;
    } bus_req_t;

endpackage

//--- core/guard_timer.sv
//==============================================================
// Purpose : Watchdog / interval timer behind an AHB-Lite slave port
// Assumes : ls_clk_pin is a free 32 kHz level from outside the domain
// Notes   : Zero wait state slave, always OKAY
//           Counter counts and pending clear keys expire only on synchronised low-speed ticks
//           Interval is taken only with the write that starts a mode
// Function
// R1 - Reset leaves block idle; mode 10 starts watchdog counting from zero.
// R2 - Running watchdog ignores mode 00 and 01; cannot be disabled.
// R3 - Interval field selects 32753, 8192, 512 or 64 periods.
// R4 - Watchdog reaching interval count raises system reset request.
// R5 - Key 0xA then 0x5 within one tick zeroes watchdog counter.
// R6 - Interval selection frozen while watchdog runs.
// R7 - No interrupt request ever while in watchdog mode.
// R8 - Mode 11 starts timer mode counting from zero.
// R9 - Timer reaching interval sets flag, gated by enable, never resets.
// R10 - In timer mode clear bit 0 zeroes counter, keeps running.
// R11 - Timer mode with mode 00 stops and zeroes counter.
// R12 - New interval accepted only from idle, with the start write.
// R13 - After watchdog entry, timer mode refused until chip reset.
// R14 - Clear field writes while idle leave counter untouched.
// R15 - Software stops timer before starting watchdog mode.
// R16 - Clear field is write-only, reads zero, resets to zero.
// R17 - Mode codes: 00 idle, 01 reserved, 10 watchdog, 11 timer.
// R18 - Counter is 15 bits, hidden, ticked at 32 kHz, retained.
// R19 - Wrong second key or late second key discards pending clear.
// R20 - Low-speed tick synchronised into bus clock domain.
module guard_timer #(
    parameter int CNT_W = guard_timer_pkg::CNT_W
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        ls_clk_pin,
    output logic             sys_reset_req,
    output logic             timer_irq
);

    //==========================================================
    // Interval decode
    function automatic logic [CNT_W-1:0] term_of(input logic [1:0] sel);
        logic [CNT_W-1:0] t;
        unique case (sel)
            2'h0: t = CNT_W'(guard_timer_pkg::TERM_SEL0);
            2'h1: t = CNT_W'(guard_timer_pkg::TERM_SEL1);
            2'h2: t = CNT_W'(guard_timer_pkg::TERM_SEL2);
            2'h3: t = CNT_W'(guard_timer_pkg::TERM_SEL3);
        endcase
        return t;
    endfunction

    //==========================================================
    // State
    guard_timer_pkg::mode_t    mode_r;
    guard_timer_pkg::mode_t    mode_nxt;
    guard_timer_pkg::bus_req_t req_r;
    guard_timer_pkg::bus_req_t req_nxt;
    logic [1:0]                interval_r;
    logic [1:0]                interval_nxt;
    logic [CNT_W-1:0]          count_r;
    logic [CNT_W-1:0]          count_nxt;
    logic [2:0]                ls_sync_r;
    logic                      armed_r;
    logic                      armed_nxt;
    logic                      aged_r;
    logic                      aged_nxt;
    logic                      wd_seen_r;
    logic                      flag_r;
    logic                      flag_nxt;
    logic                      irq_en_r;
    logic                      irq_en_nxt;
    logic                      rst_req_r;
    logic                      rst_req_nxt;
    logic [31:0]               rdata_nxt;

    //==========================================================
    // Low-speed tick: two-stage sync then edge detect
    // Third stage feeds only the edge detector
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ls_sync_r <= 3'h0;
        end else begin
            ls_sync_r <= {ls_sync_r[1:0], ls_clk_pin}; // R20
        end
    end

    // One bus-clock pulse per low-speed rising edge
    wire tick = ls_sync_r[1] & ~ls_sync_r[2]; // R18 R20

    //==========================================================
    // AHB-Lite address phase decode
    // Upper address bits are not decoded
    wire              addr_ok   = hsel & htrans[1] & hready;
    wire [11:0]       addr_lo   = haddr[11:0];
    wire              hit_ctrl  = addr_ok & (addr_lo == guard_timer_pkg::CTRL_ADDR);
    wire              hit_irq   = addr_ok & (addr_lo == guard_timer_pkg::IRQ_ADDR);

    // Address phase held over for the data phase
    assign req_nxt.ctrl_wr = hit_ctrl & hwrite;
    assign req_nxt.irq_wr  = hit_irq & hwrite;
    assign req_nxt.ctrl_rd = hit_ctrl & ~hwrite;

    // Data phase write fields
    wire [3:0]        wr_clr    = hwdata[guard_timer_pkg::CLR_LSB +: 4];
    wire [1:0]        wr_mode   = hwdata[guard_timer_pkg::MODE_LSB +: 2];
    wire [1:0]        wr_int    = hwdata[guard_timer_pkg::INT_LSB +: 2];
    wire              ctrl_wr   = req_r.ctrl_wr;
    wire              irq_wr    = req_r.irq_wr;

    //==========================================================
    // Mode control
    // Leaves idle on a start, timer returns to idle on 00
    wire in_idle  = (mode_r == guard_timer_pkg::MODE_IDLE);
    wire in_wd    = (mode_r == guard_timer_pkg::MODE_WD);
    wire in_tm    = (mode_r == guard_timer_pkg::MODE_TM);
    wire go_wd    = in_idle & ctrl_wr & (wr_mode == guard_timer_pkg::MODE_WD); // R1
    wire go_tm    = in_idle & ctrl_wr & (wr_mode == guard_timer_pkg::MODE_TM)
                    & ~wd_seen_r; // R8 R13
    wire stop_tm  = in_tm & ctrl_wr & (wr_mode == guard_timer_pkg::MODE_IDLE); // R11
    wire start    = go_wd | go_tm;

    // Watchdog stays put; 01 and timer-to-watchdog are ignored
    assign mode_nxt = go_wd   ? guard_timer_pkg::MODE_WD :  // R2 R15 R17
                      go_tm   ? guard_timer_pkg::MODE_TM :
                      stop_tm ? guard_timer_pkg::MODE_IDLE :
                      mode_r;

    // Interval taken only with the start write
    assign interval_nxt = start ? wr_int : interval_r; // R6 R12

    //==========================================================
    // Counter
    // Terminal on the tick that reaches the interval count
    wire term_hit = ~in_idle & tick
                    & (count_r == term_of(interval_r) - CNT_W'(1)); // R3
    wire key_ok   = in_wd & ctrl_wr & armed_r
                    & (wr_clr == guard_timer_pkg::CLEAR_KEY_TWO); // R5
    wire tm_clr   = in_tm & ctrl_wr & wr_clr[0]; // R10

    // Idle and stop win over keys, terminal and ticks
    assign count_nxt = (in_idle | stop_tm)   ? CNT_W'(guard_timer_pkg::CNT_RESET) : // R11 R14
                       (key_ok | tm_clr)     ? CNT_W'(guard_timer_pkg::CNT_RESET) : // R5 R10
                       term_hit              ? CNT_W'(guard_timer_pkg::CNT_RESET) :
                       tick                  ? count_r + CNT_W'(1) :
                       count_r;

    // Clear key sequence: a write disarms unless it is the first key,
    // a second tick after arming expires it
    assign armed_nxt = (in_wd & ctrl_wr) ? (wr_clr == guard_timer_pkg::CLEAR_KEY_ONE) :
                       (tick & aged_r)   ? 1'b0 :
                       armed_r; // R19
    assign aged_nxt  = (in_wd & ctrl_wr) ? 1'b0 :
                       (tick & armed_r)  ? 1'b1 :
                       aged_r; // R19

    //==========================================================
    // Events: set wins over clear
    // Reset request holds until the block is reset
    assign rst_req_nxt = rst_req_r | (in_wd & term_hit); // R4
    // Flag always records; enable gates only the pin
    assign flag_nxt    = (in_tm & term_hit) |
                         (flag_r & ~(irq_wr & hwdata[guard_timer_pkg::FLAG_BIT])); // R9
    assign irq_en_nxt  = irq_wr ? hwdata[guard_timer_pkg::EN_BIT] : irq_en_r;

    //==========================================================
    // Read data, taken at the address phase with post-write values
    wire [7:0] ctrl_view = {guard_timer_pkg::CLR_RESET, mode_nxt, interval_nxt}; // R16
    wire [7:0] irq_view  = {5'h00, rst_req_nxt, irq_en_nxt, flag_nxt};

    assign rdata_nxt = (hit_ctrl & ~hwrite) ? {24'h000000, ctrl_view} :
                       (hit_irq & ~hwrite)  ? {24'h000000, irq_view} :
                       32'h00000000;

    //==========================================================
    // Registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_r     <= guard_timer_pkg::MODE_IDLE; // R1 R17
            interval_r <= guard_timer_pkg::INT_RESET;
            count_r    <= CNT_W'(guard_timer_pkg::CNT_RESET);
            req_r      <= '0;
            armed_r    <= 1'b0;
            aged_r     <= 1'b0;
            wd_seen_r  <= 1'b0;
            flag_r     <= 1'b0;
            irq_en_r   <= 1'b0;
            rst_req_r  <= 1'b0;
        end else begin
            mode_r     <= mode_nxt;
            interval_r <= interval_nxt;
            count_r    <= count_nxt;
            req_r      <= req_nxt;
            armed_r    <= armed_nxt;
            aged_r     <= aged_nxt;
            wd_seen_r  <= wd_seen_r | go_wd; // R13
            flag_r     <= flag_nxt;
            irq_en_r   <= irq_en_nxt;
            rst_req_r  <= rst_req_nxt;
        end
    end

    // Outputs
    // Interrupt masked in watchdog mode whatever flag and enable say
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout     <= 1'b1;
            hresp         <= 1'b0;
            hrdata        <= 32'h00000000;
            sys_reset_req <= 1'b0;
            timer_irq     <= 1'b0;
        end else begin
            hreadyout     <= 1'b1;
            hresp         <= 1'b0;
            hrdata        <= rdata_nxt;
            sys_reset_req <= rst_req_nxt;
            timer_irq     <= flag_nxt & irq_en_nxt
                             & (mode_nxt != guard_timer_pkg::MODE_WD); // R7 R9
        end
    end

    //==========================================================
    // Checks
    a_wd_no_irq: assert property (@(posedge hclk) disable iff (!hresetn) // R7
        (mode_r == guard_timer_pkg::MODE_WD) |-> !timer_irq)
        else $error("interrupt raised in watchdog mode");

    a_wd_mode_locked: assert property (@(posedge hclk) disable iff (!hresetn) // R2
        (mode_r == guard_timer_pkg::MODE_WD) |=> (mode_r == guard_timer_pkg::MODE_WD))
        else $error("watchdog mode left");

    a_interval_frozen: assert property (@(posedge hclk) disable iff (!hresetn) // R6
        (mode_r != guard_timer_pkg::MODE_IDLE) |=> $stable(interval_r))
        else $error("interval changed while running");

    a_wd_reset_req: assert property (@(posedge hclk) disable iff (!hresetn) // R4
        (in_wd && tick && count_r == term_of(interval_r) - CNT_W'(1))
        |=> sys_reset_req [*3])
        else $error("no reset request on watchdog timeout");

    a_timer_no_reset: assert property (@(posedge hclk) disable iff (!hresetn) // R9
        (!wd_seen_r && mode_r == guard_timer_pkg::MODE_TM) |-> !sys_reset_req)
        else $error("reset requested in timer mode");

    a_start_from_zero: assert property (@(posedge hclk) disable iff (!hresetn) // R8
        (mode_r == guard_timer_pkg::MODE_IDLE ##1 mode_r != guard_timer_pkg::MODE_IDLE)
        |-> count_r == CNT_W'(0))
        else $error("counter not zero at start");

    a_idle_zero: assert property (@(posedge hclk) disable iff (!hresetn) // R14
        (mode_r == guard_timer_pkg::MODE_IDLE) |-> count_r == CNT_W'(0))
        else $error("counter moved while idle");

    a_clear_reads_zero: assert property (@(posedge hclk) disable iff (!hresetn) // R16
        req_r.ctrl_rd |-> hrdata[7:4] == 4'h0)
        else $error("clear field read non-zero");

    a_timer_flag_set: assert property (@(posedge hclk) disable iff (!hresetn) // R9
        (in_tm && term_hit && irq_en_r && !irq_wr) |=> (flag_r && timer_irq))
        else $error("timer interval did not raise interrupt");

    a_key_clears: assert property (@(posedge hclk) disable iff (!hresetn) // R5
        key_ok |=> count_r == CNT_W'(0))
        else $error("key sequence did not clear counter");

    a_timer_refused: assert property (@(posedge hclk) disable iff (!hresetn) // R13
        wd_seen_r |-> mode_r != guard_timer_pkg::MODE_TM)
        else $error("timer mode entered after watchdog");

    // Mode entry and exit
    a_wd_entry: assert property (@(posedge hclk) disable iff (!hresetn) // R1
        go_wd |=> (mode_r == guard_timer_pkg::MODE_WD && count_r == CNT_W'(0)))
        else $error("watchdog not entered from zero");

    a_tm_entry: assert property (@(posedge hclk) disable iff (!hresetn) // R8
        go_tm |=> (mode_r == guard_timer_pkg::MODE_TM && count_r == CNT_W'(0)))
        else $error("timer not entered from zero");

    a_rsvd_ignored: assert property (@(posedge hclk) disable iff (!hresetn) // R17
        (in_idle && ctrl_wr && wr_mode == 2'h1) |=> (mode_r == guard_timer_pkg::MODE_IDLE))
        else $error("reserved mode code accepted");

    a_timer_stop: assert property (@(posedge hclk) disable iff (!hresetn) // R11
        stop_tm |=> (mode_r == guard_timer_pkg::MODE_IDLE && count_r == CNT_W'(0)))
        else $error("timer not stopped and zeroed");

    a_tm_to_wd: assert property (@(posedge hclk) disable iff (!hresetn) // R15
        (in_tm && ctrl_wr && wr_mode == 2'h2) |=> (mode_r == guard_timer_pkg::MODE_TM))
        else $error("watchdog entered straight from timer");

    // Counter behaviour
    a_timer_clear: assert property (@(posedge hclk) disable iff (!hresetn) // R10
        tm_clr |=> count_r == CNT_W'(0))
        else $error("timer clear bit did not zero counter");

    a_count_hold: assert property (@(posedge hclk) disable iff (!hresetn) // R18
        (!tick && !ctrl_wr) |=> $stable(count_r))
        else $error("counter moved without a tick");

    a_count_step: assert property (@(posedge hclk) disable iff (!hresetn) // R18
        (in_tm && tick && !ctrl_wr && !term_hit) |=> count_r == $past(count_r) + CNT_W'(1))
        else $error("counter did not advance on tick");

    // Clear key sequence
    a_key_armed: assert property (@(posedge hclk) disable iff (!hresetn) // R5
        (in_wd && ctrl_wr && wr_clr == guard_timer_pkg::CLEAR_KEY_ONE) |=> armed_r)
        else $error("first key did not arm clear");

    a_clear_discard: assert property (@(posedge hclk) disable iff (!hresetn) // R19
        (in_wd && ctrl_wr && wr_clr != guard_timer_pkg::CLEAR_KEY_ONE) |=> !armed_r)
        else $error("pending clear kept after other write");

    a_clear_expire: assert property (@(posedge hclk) disable iff (!hresetn) // R19
        (tick && aged_r && !ctrl_wr) |=> !armed_r)
        else $error("pending clear kept past one tick");

    // Events
    a_rst_sticky: assert property (@(posedge hclk) disable iff (!hresetn) // R4
        sys_reset_req |=> sys_reset_req)
        else $error("reset request dropped");

    a_rst_only_wd: assert property (@(posedge hclk) disable iff (!hresetn) // R9
        (!in_wd && !sys_reset_req) |=> !sys_reset_req)
        else $error("reset request outside watchdog mode");

    a_irq_gated: assert property (@(posedge hclk) disable iff (!hresetn) // R9
        timer_irq |-> (flag_r && irq_en_r))
        else $error("interrupt without flag and enable");

    a_flag_set_wins: assert property (@(posedge hclk) disable iff (!hresetn) // R9
        (in_tm && term_hit) |=> flag_r)
        else $error("flag lost on timer interval");

    a_flag_hold: assert property (@(posedge hclk) disable iff (!hresetn) // R9
        (!(in_tm && term_hit) && !irq_wr) |=> $stable(flag_r))
        else $error("flag changed without event or write");

endmodule

//--- bench/guard_timer_tb.sv
//==============================================================
// Purpose : Self-checking bench for the watchdog / interval timer
// Assumes : Zero wait state slave, low-speed tick every 8 bus clocks
// Notes   : Interval 11 (64 ticks) keeps every timeout short
module guard_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hready;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        ls_clk_pin = 1'b0;
    logic [2:0]  ls_div = 3'h0;
    logic        sys_reset_req;
    logic        timer_irq;
    logic [31:0] rd;
    int          err_count;
    int          samples_checked;
    int          i;
    localparam logic [31:0] CTRL = {20'h0, guard_timer_pkg::CTRL_ADDR};
    localparam logic [31:0] IRQR = {20'h0, guard_timer_pkg::IRQ_ADDR};
    localparam logic [39:0] LOCK_TRY = 40'h0f_08_0c_04_00;

    assign hready = hreadyout;

    guard_timer guard_timer_i (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .hsel          (hsel),
        .haddr         (haddr),
        .htrans        (htrans),
        .hwrite        (hwrite),
        .hsize         (3'h2),
        .hwdata        (hwdata),
        .hready        (hready),
        .hreadyout     (hreadyout),
        .hrdata        (hrdata),
        .hresp         (hresp),
        .ls_clk_pin    (ls_clk_pin),
        .sys_reset_req (sys_reset_req),
        .timer_irq     (timer_irq)
    );

    //==========================================================
    // Clocks and bus tasks
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        ls_div     <= ls_div + 3'h1;
        ls_clk_pin <= ls_div[2];
    end

    task automatic ahb_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] data);
        hsel   <= 1'b1;
        haddr  <= addr;
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= data;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rd_check(input string name, input logic [31:0] addr, input logic [31:0] exp);
        ahb_xfer(1'b0, addr, 32'h0);
        check(name, exp, rd);
    endtask

    task automatic ticks(input int n);
        repeat (n * 8) @(posedge hclk);
    endtask

    // Waits a bounded number of ticks for reset request (sel 1) or irq (sel 0)
    task automatic wait_high(input logic sel, input int n);
        for (int k = 0; k < n * 8 && (sel ? sys_reset_req : timer_irq) !== 1'b1; k++)
            @(posedge hclk);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        final_report;
    end

    //==========================================================
    // Test sequence
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
        hwrite = 1'b0; hwdata = 32'h0;
        err_count = 0; samples_checked = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_check("ctrl_reset", CTRL, 32'h0);
        rd_check("irq_reset", IRQR, 32'h0);
        rd_check("unmapped", 32'h400, 32'h0);
        ahb_xfer(1'b1, IRQR, 32'h2);
        ahb_xfer(1'b1, CTRL, 32'h0f);
        rd_check("ctrl_timer", CTRL, 32'h0f);
        ticks(50);
        check("irq_early", 32'h0, {31'h0, timer_irq});
        wait_high(1'b0, 30);
        check("irq_term", 32'h1, {31'h0, timer_irq});
        check("tm_no_rst", 32'h0, {31'h0, sys_reset_req});
        rd_check("irq_flag", IRQR, 32'h3);
        ahb_xfer(1'b1, IRQR, 32'h3);
        rd_check("irq_clear", IRQR, 32'h2);
        for (i = 0; i < 4; i++) begin
            ticks(40);
            ahb_xfer(1'b1, CTRL, 32'h1c);
        end
        check("tm_cleared", 32'h0, {31'h0, timer_irq});
        rd_check("tm_int_kept", CTRL, 32'h0f);
        wait_high(1'b0, 70);
        check("tm_int_64", 32'h1, {31'h0, timer_irq});
        ahb_xfer(1'b1, IRQR, 32'h3);
        ahb_xfer(1'b1, CTRL, 32'h00);
        rd_check("tm_stop", CTRL, 32'h3);
        ahb_xfer(1'b1, CTRL, 32'hf0);
        ticks(70);
        check("stopped", 32'h0, {31'h0, timer_irq});
        ahb_xfer(1'b1, CTRL, 32'h07);
        rd_check("mode_rsvd", CTRL, 32'h3);
        ahb_xfer(1'b1, CTRL, 32'h0f);
        wait_high(1'b0, 70);
        check("tm_again", 32'h1, {31'h0, timer_irq});
        ahb_xfer(1'b1, CTRL, 32'h0b);
        rd_check("tm_no_wd", CTRL, 32'h0f);
        ahb_xfer(1'b1, CTRL, 32'h00);
        ahb_xfer(1'b1, CTRL, 32'h0b);
        rd_check("wd_start", CTRL, 32'h0b);
        check("wd_masked", 32'h0, {31'h0, timer_irq});
        rd_check("wd_flag", IRQR, 32'h3);
        for (i = 0; i < 5; i++) begin
            ahb_xfer(1'b1, CTRL, {24'h0, LOCK_TRY[i*8 +: 8]});
            rd_check("wd_locked", CTRL, 32'h0b);
        end
        for (i = 0; i < 5; i++) begin
            ticks(40);
            ahb_xfer(1'b1, CTRL, 32'hab);
            ahb_xfer(1'b1, CTRL, 32'h5b);
        end
        check("wd_kicked", 32'h0, {31'h0, sys_reset_req});
        check("wd_no_irq", 32'h0, {31'h0, timer_irq});
        ticks(30);
        ahb_xfer(1'b1, CTRL, 32'hab);
        ticks(3);
        ahb_xfer(1'b1, CTRL, 32'h5b);
        ahb_xfer(1'b1, CTRL, 32'hab);
        ahb_xfer(1'b1, CTRL, 32'h3b);
        ahb_xfer(1'b1, CTRL, 32'h5b);
        wait_high(1'b1, 40);
        check("wd_timeout", 32'h1, {31'h0, sys_reset_req});
        rd_check("rst_status", IRQR, 32'h7);
        check("wd_irq_off", 32'h0, {31'h0, timer_irq});
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check("rst_cleared", 32'h0, {31'h0, sys_reset_req});
        rd_check("idle_again", CTRL, 32'h0);
        ahb_xfer(1'b1, CTRL, 32'h0f);
        rd_check("tm_after_rst", CTRL, 32'h0f);
        final_report;
    end
endmodule
